// File: dpc_defines.vh
`ifndef DPC_DEFINES_VH
`define DPC_DEFINES_VH
// Clock rate and timing figures as printed, in their own units
`define DPC_CLK_MHZ 250
`define DPC_T_CS_SETUP_NS 100
`define DPC_T_DIR_HOLD_NS 100
`define DPC_T_DIR_SETUP_NS 2900
`define DPC_T_LOW_NS 1000
`define DPC_T_HIGH_NS 1000
`define DPC_T_STROBE_TO_CS_NS 1000
`define DPC_T_DESEL_NOSTORE_NS 100
`define DPC_T_DESEL_STORE_MS 20
`define DPC_TAP_SETTLE_TIME_NS 100000
// Least times round up to whole cycles
`define DPC_CYC_NS(t) (((t) * `DPC_CLK_MHZ + 999) / 1000)
`define DPC_CYC_MS(t) ((t) * `DPC_CLK_MHZ * 1000)
// Store deselect time in cycles at the counter width (20 ms at 250 MHz)
`define DPC_STORE_CYC 24'h4C4B40
// Position range: 100 taps, 7-bit code
`define DPC_POS_W 7
`define DPC_POS_MAX 7'h63
`define DPC_CNT_W 24
`define DPC_CNT_ONE 24'h000001
// Operation codes on the command port
`define DPC_OP_MOVE 1'b0
`define DPC_OP_STORE 1'b1
`endif

// File: dpc_wiper_host.v
`timescale 1ns/10ps
`default_nettype none
`include "dpc_defines.vh"
// How it works
// - No store: raise select, strobe low
// - Select high 20 ms after store
// - Select high 100 ns without store
// - Direction hold 100 ns, setup 2.9 us
// - Wait 1 us before raising select
// - Direction may change within a selection
// - Never lower select with strobe low
module dpc_wiper_host #(
  // Store wait in cycles; a bench may shorten it, silicon needs the full figure
  parameter [`DPC_CNT_W-1:0] STORE_WAIT = `DPC_STORE_CYC
) (
  input wire mclk_i, // System clock
  input wire reset_i, // Synchronous reset, active high
  input wire cmd_valid_i, // Command request
  input wire cmd_op_i, // 0 move, 1 store
  input wire cmd_up_i, // Move direction, 1 toward high end
  input wire [`DPC_POS_W-1:0] cmd_steps_i, // Number of steps to move
  output reg cmd_ready_o, // Ready for a command
  output reg cs_n_o, // Chip select, active low
  output reg step_n_o, // Step strobe, falling edge active
  output reg dir_up_o, // Direction level
  output reg [`DPC_POS_W-1:0] pos_o // Tracked wiper position
);
  // Least times in whole cycles, worked out at full width first
  localparam integer I_CS = `DPC_CYC_NS(`DPC_T_CS_SETUP_NS);
  localparam integer I_DH = `DPC_CYC_NS(`DPC_T_DIR_HOLD_NS);
  localparam integer I_DS = `DPC_CYC_NS(`DPC_T_DIR_SETUP_NS);
  localparam integer I_LO = `DPC_CYC_NS(`DPC_T_LOW_NS);
  localparam integer I_HI = `DPC_CYC_NS(`DPC_T_HIGH_NS);
  localparam integer I_IC = `DPC_CYC_NS(`DPC_T_STROBE_TO_CS_NS);
  localparam integer I_NS = `DPC_CYC_NS(`DPC_T_DESEL_NOSTORE_NS);
  // Then cut to the counter width on purpose; each figure fits with room to spare
  localparam [`DPC_CNT_W-1:0] C_CS = I_CS[`DPC_CNT_W-1:0];
  localparam [`DPC_CNT_W-1:0] C_DH = I_DH[`DPC_CNT_W-1:0];
  localparam [`DPC_CNT_W-1:0] C_DS = I_DS[`DPC_CNT_W-1:0];
  localparam [`DPC_CNT_W-1:0] C_LO = I_LO[`DPC_CNT_W-1:0];
  localparam [`DPC_CNT_W-1:0] C_HI = I_HI[`DPC_CNT_W-1:0];
  localparam [`DPC_CNT_W-1:0] C_IC = I_IC[`DPC_CNT_W-1:0];
  localparam [`DPC_CNT_W-1:0] C_NS = I_NS[`DPC_CNT_W-1:0];
  localparam [`DPC_CNT_W-1:0] C_ST = STORE_WAIT;
  // High phase must cover both its own least time and the direction hold
  localparam [`DPC_CNT_W-1:0] C_HOLD = (C_HI > C_DH) ? C_HI : C_DH;
  // Deselect gap doubles as the direction hold after the strobe returns high
  localparam [`DPC_CNT_W-1:0] C_GAP = (C_NS > C_DH) ? C_NS : C_DH;
  // Sequencer states; select is low from S_SEL through S_PRE
  localparam [2:0] S_IDLE = 3'h0;
  localparam [2:0] S_SEL = 3'h1;
  localparam [2:0] S_LOW = 3'h2;
  localparam [2:0] S_HIGH = 3'h3;
  localparam [2:0] S_PRE = 3'h4;
  localparam [2:0] S_DESEL = 3'h5;
  localparam [2:0] S_STORE = 3'h6;
  // Registered state, phase counter, steps left, operation and their next values
  reg [2:0] state_ff, nxt_state;
  reg [`DPC_CNT_W-1:0] cnt_ff, nxt_cnt;
  reg [`DPC_POS_W-1:0] left_ff, nxt_left;
  reg op_ff, nxt_op;
  reg nxt_cs_n, nxt_step_n, nxt_dir, nxt_ready;
  reg [`DPC_POS_W-1:0] nxt_pos;
  // Phase counter: loaded with a phase length, done on its last cycle
  wire cnt_done = (cnt_ff <= `DPC_CNT_ONE);
  wire [`DPC_CNT_W-1:0] cnt_dec = cnt_ff - `DPC_CNT_ONE;
  // Sequencer: every count is a least figure; the part saturates and pos_o mirrors it.
  // One move of N steps, as seen on the pins:
  //   select falls with the direction set, then the direction setup runs out
  //   each step is a strobe fall, a low phase, then a high phase that also
  //   covers the direction hold
  //   the last fall is left standing, so select rises with the strobe low (no store)
  //   the strobe returns high only once select is high, then the deselect gap runs
  // A store selects, waits the select setup and then 1 us with the strobe high, raises select
  // and then sits out the whole store time before it takes the next command.
  // Limitations a user must know:
  //   the host cannot read the recalled position, so pos_o starts at zero after
  //   reset; a full move down first makes it true
  //   a zero move is taken but touches no pin, since any select would store or step
  //   the store time is counted, not observed, so STORE_WAIT must cover the part
  //   step counts beyond the range are clamped in pos_o, as the part clamps them
  always @* begin
    // Defaults: hold every pin, count down, ready only where asked
    nxt_state = state_ff;
    nxt_cnt = cnt_done ? cnt_ff : cnt_dec;
    nxt_left = left_ff;
    nxt_op = op_ff;
    nxt_cs_n = cs_n_o;
    nxt_step_n = step_n_o;
    nxt_dir = dir_up_o;
    nxt_ready = 1'b0;
    nxt_pos = pos_o;
    case (state_ff)
      S_IDLE: begin
        // Idle: ready stands until a command is taken
        nxt_ready = 1'b1;
        if (cmd_valid_i && cmd_ready_o) begin
          nxt_ready = 1'b0;
          nxt_op = cmd_op_i;
          nxt_left = cmd_steps_i;
          nxt_cs_n = 1'b0;
          nxt_dir = cmd_up_i;
          // Direction settles before the first fall; the setup bound dominates select
          nxt_cnt = C_DS;
          nxt_state = S_SEL;
          if (cmd_op_i == `DPC_OP_STORE) begin
            // A store sends no steps; the select setup is waited, then 1 us in S_PRE
            nxt_cnt = C_CS;
            nxt_left = {`DPC_POS_W{1'b0}};
          end else if (cmd_steps_i == {`DPC_POS_W{1'b0}}) begin
            // A zero move touches no pin: a select and deselect would store or step
            nxt_cs_n = 1'b1;
            nxt_dir = dir_up_o;
            nxt_state = S_IDLE;
          end
        end
      end
      S_SEL: begin
        // Selected: wait out the setup, then fire the next fall
        if (cnt_done) begin
          if (left_ff == {`DPC_POS_W{1'b0}}) begin
            nxt_cnt = C_IC;
            nxt_state = S_PRE;
          end else begin
            nxt_step_n = 1'b0;
            nxt_cnt = C_LO;
            nxt_left = left_ff - 7'h01;
            // Mirror the part: clamp at both ends instead of wrapping
            if (dir_up_o && pos_o != `DPC_POS_MAX)
              nxt_pos = pos_o + 7'h01;
            else if (!dir_up_o && pos_o != {`DPC_POS_W{1'b0}})
              nxt_pos = pos_o - 7'h01;
            nxt_state = S_LOW;
          end
        end
      end
      S_LOW: begin
        // Strobe low phase; after the last fall it stays low into the deselect
        if (cnt_done) begin
          if (left_ff == {`DPC_POS_W{1'b0}}) begin
            nxt_cnt = C_IC;
            nxt_state = S_PRE;
          end else begin
            nxt_step_n = 1'b1;
            // High phase covers both 1 us and direction hold
            nxt_cnt = C_HOLD;
            nxt_state = S_HIGH;
          end
        end
      end
      S_HIGH: begin
        // Strobe high phase; the direction is held through it
        if (cnt_done) begin
          nxt_cnt = `DPC_CNT_ONE;
          nxt_state = S_SEL;
        end
      end
      S_PRE: begin
        // Strobe holds its final level here: high for a store, low after a move
        if (cnt_done) begin
          nxt_cs_n = 1'b1;
          if (op_ff == `DPC_OP_STORE) begin
            // Strobe is high here, so this rise stores
            nxt_cnt = C_ST;
            nxt_state = S_STORE;
          end else begin
            // Strobe is low here, so this rise leaves the store untouched
            nxt_cnt = C_GAP;
            nxt_state = S_DESEL;
          end
        end
      end
      S_DESEL, S_STORE: begin
        // Select is already high, so the strobe can rise without an edge being seen
        nxt_step_n = 1'b1;
        if (cnt_done) begin
          // Ready returns only once the gap or the store time is over
          nxt_ready = 1'b1;
          nxt_state = S_IDLE;
        end
      end
      default: nxt_state = S_IDLE;
    endcase
  end
  // Strobe is only lowered after select is low, never the reverse
  always @(posedge mclk_i) begin
    // Every output is a flip-flop, so the pins never glitch between phases
    // Reset parks the pins in standby: deselected, strobe high
    if (reset_i) begin
      state_ff <= S_IDLE;
      cnt_ff <= 24'h000000;
      left_ff <= 7'h00;
      op_ff <= 1'b0;
      cs_n_o <= 1'b1;
      step_n_o <= 1'b1;
      dir_up_o <= 1'b0;
      cmd_ready_o <= 1'b0;
      pos_o <= 7'h00;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      left_ff <= nxt_left;
      op_ff <= nxt_op;
      cs_n_o <= nxt_cs_n;
      step_n_o <= nxt_step_n;
      dir_up_o <= nxt_dir;
      cmd_ready_o <= nxt_ready;
      pos_o <= nxt_pos;
    end
  end
endmodule // dpc_wiper_host
`default_nettype wire

// File: dpc_pot_model.sv
`timescale 1ns/10ps
`default_nettype none
`include "dpc_defines.vh"
module dpc_pot_model (
  input wire cs_n_i, // Select
  input wire step_n_i, // Strobe
  input wire dir_up_i, // Direction
  output reg [6:0] pos_o, // Counter
  output reg [6:0] nv_o, // Stored value
  output reg tap_on_o // Selected tap connected
);
  reg [99:0] taps = 100'h1; // Connected taps, tap 0 after recall
  realtime moved = 0.0; // Time of the last tap change
  // Recall at power-up; a blank store reads zero
  initial nv_o = 7'h00;
  initial pos_o = 7'h00;
  // Steps only while selected, clamped at both ends
  always @(negedge step_n_i) begin
    if (!cs_n_i && dir_up_i && pos_o < 7'h63)
      pos_o <= pos_o + 7'h01;
    else if (!cs_n_i && !dir_up_i && pos_o > 7'h00)
      pos_o <= pos_o - 7'h01;
  end
  // Store only when strobe is high at deselect
  always @(posedge cs_n_i)
    if (step_n_i) nv_o <= pos_o;
  // Make-before-break: a new tap joins at once, the others drop once settled
  always @(pos_o) begin
    taps = taps | (100'h1 << pos_o);
    moved = $realtime;
  end
  always #1000 if ($realtime - moved >= `DPC_TAP_SETTLE_TIME_NS) taps = 100'h1 << pos_o;
  always @* tap_on_o = taps[pos_o];
endmodule // dpc_pot_model
`default_nettype wire

// File: dpc_wiper_host_properties.sv
`timescale 1ns/10ps
`default_nettype none
module dpc_props (
  input wire mclk_i, // Clock
  input wire reset_i, // Reset
  input wire cs_n_o, // Select
  input wire step_n_o, // Strobe
  input wire dir_up_o, // Direction
  input wire [6:0] pos_o // Position
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (reset_i);
  reg [9:0] run_ff; // Strobe level age, starts full
  reg [9:0] hi_ff; // Deselect age, starts full
  reg [9:0] dir_ff; // Direction level age, starts full
  // Ages saturate so long idles never wrap; full after reset means long ago
  always @(posedge mclk_i) begin
    run_ff <= reset_i ? 10'h3FF : $changed(step_n_o) ? 10'h001 : run_ff + {9'h000, ~&run_ff};
    hi_ff <= reset_i ? 10'h3FF : cs_n_o ? hi_ff + {9'h000, ~&hi_ff} : 10'h000;
    dir_ff <= reset_i ? 10'h3FF : $changed(dir_up_o) ? 10'h001 : dir_ff + {9'h000, ~&dir_ff};
  end
  step_sel_a: assert property ($fell(step_n_o) |-> !cs_n_o)
    else $error("strobe unselected");
  step_up_a: assert property ($fell(step_n_o) && dir_up_o && $past(pos_o) < 7'h63
    |-> pos_o == $past(pos_o) + 7'h01) else $error("up step lost");
  step_dn_a: assert property ($fell(step_n_o) && !dir_up_o && $past(pos_o) > 7'h00
    |-> pos_o == $past(pos_o) - 7'h01) else $error("down step lost");
  end_sat_a: assert property ($fell(step_n_o) && $past(pos_o) == (dir_up_o ? 7'h63 : 7'h00)
    |-> $stable(pos_o)) else $error("end wrapped");
  pos_range_a: assert property (pos_o <= 7'h63) else $error("no such tap");
  phase_min_a: assert property ($changed(step_n_o) |-> run_ff >= 10'h0FA)
    else $error("strobe phase short");
  desel_wait_a: assert property ($rose(cs_n_o) |-> run_ff >= 10'h0FA)
    else $error("deselect early");
  resel_gap_a: assert property ($fell(cs_n_o) |-> step_n_o && hi_ff >= 10'h019)
    else $error("reselect bad");
  dir_hold_a: assert property ($changed(dir_up_o) |-> step_n_o && run_ff >= 10'h019)
    else $error("direction moved early");
  dir_setup_a: assert property ($fell(step_n_o) |-> dir_ff >= 10'h2D5)
    else $error("direction setup short");
endmodule // dpc_props
bind dpc_wiper_host dpc_props props (.mclk_i(mclk_i), .reset_i(reset_i), .cs_n_o(cs_n_o),
  .step_n_o(step_n_o), .dir_up_o(dir_up_o), .pos_o(pos_o));
`default_nettype wire

// File: dpc_wiper_host_test.sv
`timescale 1ns/10ps
`default_nettype none
module dpc_wiper_host_test;
  reg mclk_i = 1'b0;
  reg reset_i = 1'b1;
  reg cmd_valid_i = 1'b0;
  reg cmd_op_i = 1'b0;
  reg cmd_up_i = 1'b0;
  reg [6:0] cmd_steps_i = 7'h00;
  wire cmd_ready_o, cs_n_o, step_n_o, dir_up_o;
  wire [6:0] pos_o, dev_pos, dev_nv;
  wire dev_tap;
  reg [6:0] exp_pos = 7'h00;
  reg [6:0] exp_nv = 7'h00;
  reg [31:0] r;
  integer fails = 0, n_checks = 0, seed = 14052, i, k, v;
  always #2 mclk_i = ~mclk_i;
  dpc_wiper_host #(.STORE_WAIT(24'h000032)) DUT (.mclk_i(mclk_i), .reset_i(reset_i),
    .cmd_valid_i(cmd_valid_i), .cmd_op_i(cmd_op_i), .cmd_up_i(cmd_up_i), .cmd_steps_i(cmd_steps_i),
    .cmd_ready_o(cmd_ready_o), .cs_n_o(cs_n_o), .step_n_o(step_n_o), .dir_up_o(dir_up_o), .pos_o(pos_o));
  dpc_pot_model dev (.cs_n_i(cs_n_o), .step_n_i(step_n_o), .dir_up_i(dir_up_o), .pos_o(dev_pos),
    .nv_o(dev_nv), .tap_on_o(dev_tap));
  // Move target, clamped at both ends
  function [6:0] move_to(input [6:0] p, input up, input [6:0] n);
    begin
      v = up ? p + n : p - n;
      move_to = v > 99 ? 7'h63 : v < 0 ? 7'h00 : v[6:0];
    end
  endfunction
  task check(input [63:0] what, input [6:0] exp, input [6:0] got);
    begin
      n_checks = n_checks + 1;
      if (got !== exp) begin
        fails = fails + 1;
        $display("ERROR %0s expected %h seen %h", what, exp, got);
      end
    end
  endtask
  task give_verdict;
    begin
      if (fails == 0 && n_checks > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask
  // Bounded wait; a hang ends the run as a failure
  task wait_ready;
    begin
      for (k = 0; k < 70000 && cmd_ready_o !== 1'b1; k = k + 1)
        @(posedge mclk_i);
      if (k == 70000) begin
        fails = fails + 1;
        give_verdict;
      end
    end
  endtask
  task run(input op, input up, input [6:0] n);
    begin
      wait_ready;
      cmd_valid_i <= 1'b1;
      cmd_op_i <= op;
      cmd_up_i <= up;
      cmd_steps_i <= n;
      @(posedge mclk_i);
      cmd_valid_i <= 1'b0;
      @(posedge mclk_i);
      wait_ready;
      exp_pos = op ? exp_pos : move_to(exp_pos, up, n);
      exp_nv = op ? exp_pos : exp_nv;
      check("position", exp_pos, pos_o);
      check("device", exp_pos, dev_pos);
      check("stored", exp_nv, dev_nv);
      check("tap", 7'h01, {6'h00, dev_tap});
    end
  endtask
  initial begin
    repeat (6) @(posedge mclk_i);
    reset_i <= 1'b0;
    @(posedge mclk_i);
    run(1'b0, 1'b0, 7'h02);
    run(1'b0, 1'b1, 7'h00);
    run(1'b0, 1'b1, 7'h69);
    run(1'b1, 1'b0, 7'h00);
    for (i = 0; i < 6; i = i + 1) begin
      r = $random(seed);
      run(r[7], r[8], {4'h0, r[2:0]});
    end
    give_verdict;
  end
endmodule // dpc_wiper_host_test
`default_nettype wire
